// *** logic/dp_diag_pkg.sv ***
// Constants, register map and types of the diagnostic response framer
package dp_diag_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map: block offsets relative to the base, own registers fixed
  localparam logic [7:0] OFS_TRIG = 8'h00; // Diagnostic status byte
  localparam logic [7:0] OFS_PAY = 8'h01; // First user payload byte
  localparam logic [7:0] BLK_LEN = 8'h06; // Status byte plus five bytes
  localparam logic [7:0] ADR_BASE = 8'h80; // Block base location
  localparam logic [7:0] ADR_STAT1 = 8'h81; // Station status one flags
  localparam logic [7:0] ADR_STAT2 = 8'h82; // Station status two flags
  localparam logic [7:0] ADR_IRQ_ST = 8'h83; // Sticky event flags, W1C
  localparam logic [7:0] ADR_IRQ_MSK = 8'h84; // Event enable mask
  localparam logic [7:0] ADR_ERR = 8'h85; // Latched error message code
  localparam logic [7:0] ADR_MADDR = 8'h86; // Parametrizing master
  localparam logic [7:0] ADR_ENG = 8'h87; // Engine state, read only

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [5:0] BASE_RST = 6'h00;
  localparam logic [7:0] STAT1_RST = 8'h02; // Not ready until told
  localparam logic [7:0] STAT2_RST = 8'h04;
  localparam logic [7:0] ERR_RST = 8'h00;
  localparam logic [7:0] MADDR_RST = 8'hff; // No master yet
  localparam logic [2:0] MSK_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Response layout
  localparam logic [3:0] FRAME_LAST = 4'hf; // Sixteen bytes, 0..15
  localparam logic [3:0] IDX_STAT1 = 4'h0;
  localparam logic [3:0] IDX_STAT2 = 4'h1;
  localparam logic [3:0] IDX_STAT3 = 4'h2;
  localparam logic [3:0] IDX_MADDR = 4'h3;
  localparam logic [3:0] IDX_ID_HI = 4'h4;
  localparam logic [3:0] IDX_ID_LO = 4'h5;
  localparam logic [3:0] IDX_LEN = 4'h6;
  localparam logic [3:0] IDX_MSG = 4'h7;
  localparam logic [3:0] IDX_USER = 4'hb; // First user byte
  localparam logic [7:0] STAT1_MASK = 8'h5e; // Bits 1,2,3,4,6 live
  localparam logic [7:0] STAT2_MASK = 8'h3b; // Bits 0,1,3,4,5 live
  localparam logic [7:0] STAT2_ONE = 8'h04; // Bit 2 always one
  localparam int OVF_BIT = 7;
  localparam logic [7:0] LEN_CODE = 8'h0a; // Code 00, length 001010

  ////////////////////////////////////////////////////////////////////////////
  // Message codes
  localparam logic [7:0] MSG_PRM_LEN = 8'h12;
  localparam logic [7:0] MSG_CFG_LEN = 8'h13;
  localparam logic [7:0] MSG_CFG_ENTRY = 8'h14;
  localparam logic [7:0] MSG_BUF_CALC = 8'h15;
  localparam logic [7:0] MSG_CFG_MISS = 8'h16;
  localparam logic [7:0] MSG_PRM_CFG = 8'h17;
  localparam logic [7:0] MSG_USER_OK = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic status byte fields
  localparam int TRIG_VALID = 0;
  localparam int TRIG_DEL = 1;
  localparam logic [7:0] TRIG_MASK = 8'h03;
  localparam logic [7:0] TRIG_IGNORE = 8'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Event flags
  localparam int IRQ_SENT = 0; // A response left completely
  localparam int IRQ_IGN = 1; // A status write was ignored
  localparam int IRQ_OVF = 2; // A request arrived while one waited
  localparam int IRQ_W = 3;

  // Frame engine states
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} frm_state_t;

endpackage

// *** logic/dp_sticky_flag.sv ***
// One sticky event flag, set by hardware, cleared by software
`timescale 1ns/1ps
module dp_sticky_flag (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);

  logic flag_r;
  logic flag_nxt;

  // Set wins so an event in the clearing cycle is kept
  assign flag_nxt = set_i | (flag_r & ~clr_i);
  assign flag_o = flag_r;

  // Flag register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule // dp_sticky_flag

// *** logic/dp_diag_framer.sv ***
// Diagnostic response framer of a fieldbus slave with register port
`timescale 1ns/1ps
module dp_diag_framer #(
  parameter logic [15:0] IDENT = 16'h5a3c // Arbitrary value
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Master side events
  input wire logic diag_req_i,
  input wire logic parm_event_i,
  input wire logic [7:0] parm_master_i,
  input wire logic err_event_i,
  input wire logic [7:0] err_code_i,
  // Response byte stream
  output logic frame_valid_o,
  input wire logic frame_ready_i,
  output logic [7:0] frame_byte_o,
  output logic frame_last_o,
  // Interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] trig_r; // Diagnostic status byte
  logic [39:0] pay_r; // User bytes, byte k at [8k+:8]
  logic [39:0] pay_nxt;
  logic [5:0] base_r; // Six bits keep block below own registers
  logic [7:0] stat1_r;
  logic [7:0] stat2_r;
  logic [7:0] err_r; // Last error message code
  logic [7:0] maddr_r; // Master that parametrized us
  logic ovf_r; // Overflow shown in status three
  logic pend_r; // A response is waiting to go
  logic [2:0] msk_r;
  logic [2:0] flag_w;
  dp_diag_pkg::frm_state_t state_r;
  dp_diag_pkg::frm_state_t state_nxt;
  logic [3:0] idx_r; // Byte being sent
  logic [7:0] byte_r;
  logic [7:0] byte_nxt;
  logic last_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire [7:0] base_w = {2'b00, base_r};
  wire [7:0] rel_w = addr_i - base_w;
  wire in_blk = (addr_i >= base_w) && (rel_w < dp_diag_pkg::BLK_LEN);
  wire wr_trig = wr_i && in_blk && (rel_w == dp_diag_pkg::OFS_TRIG);
  wire wr_pay = wr_i && in_blk && (rel_w >= dp_diag_pkg::OFS_PAY);
  wire [2:0] pay_sel = 3'(rel_w - dp_diag_pkg::OFS_PAY);
  wire wr_base = wr_i && (addr_i == dp_diag_pkg::ADR_BASE);
  wire wr_stat1 = wr_i && (addr_i == dp_diag_pkg::ADR_STAT1);
  wire wr_stat2 = wr_i && (addr_i == dp_diag_pkg::ADR_STAT2);
  wire wr_irq = wr_i && (addr_i == dp_diag_pkg::ADR_IRQ_ST);
  wire wr_msk = wr_i && (addr_i == dp_diag_pkg::ADR_IRQ_MSK);

  ////////////////////////////////////////////////////////////////////////////
  // Status byte decode
  // ignore both bits
  wire trig_ign = wr_trig && (wdata_i == dp_diag_pkg::TRIG_IGNORE);
  wire trig_take = wr_trig && !trig_ign;
  wire trig_rise = trig_take && !trig_r[dp_diag_pkg::TRIG_VALID] &&
                   wdata_i[dp_diag_pkg::TRIG_VALID];
  wire trig_del = trig_take && wdata_i[dp_diag_pkg::TRIG_DEL];

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine control
  // request, rising valid bit or error
  wire start_evt = diag_req_i || trig_rise || err_event_i;
  wire idle_w = (state_r == dp_diag_pkg::ST_IDLE);
  wire take_w = idle_w && pend_r;
  wire beat_w = (state_r == dp_diag_pkg::ST_SEND) && frame_ready_i;
  wire done_w = beat_w && (idx_r == dp_diag_pkg::FRAME_LAST);
  // Only one response can wait; a further one is lost
  wire ovf_evt = start_evt && pend_r && !take_w;

  // Engine next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dp_diag_pkg::ST_IDLE: begin
        if (pend_r) begin
          state_nxt = dp_diag_pkg::ST_LOAD;
        end
      end
      dp_diag_pkg::ST_LOAD: begin
        state_nxt = dp_diag_pkg::ST_SEND;
      end
      dp_diag_pkg::ST_SEND: begin
        if (done_w) begin
          state_nxt = dp_diag_pkg::ST_IDLE;
        end else if (frame_ready_i) begin
          state_nxt = dp_diag_pkg::ST_LOAD;
        end
      end
      default: begin
        state_nxt = dp_diag_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response byte builder
  always_comb begin
    byte_nxt = 8'h00;
    case (idx_r)
      dp_diag_pkg::IDX_STAT1: byte_nxt = stat1_r & dp_diag_pkg::STAT1_MASK;
      dp_diag_pkg::IDX_STAT2: begin
        byte_nxt = (stat2_r & dp_diag_pkg::STAT2_MASK) |
                   dp_diag_pkg::STAT2_ONE;
      end
      dp_diag_pkg::IDX_STAT3: byte_nxt[dp_diag_pkg::OVF_BIT] = ovf_r;
      dp_diag_pkg::IDX_MADDR: byte_nxt = maddr_r;
      dp_diag_pkg::IDX_ID_HI: byte_nxt = IDENT[15:8];
      dp_diag_pkg::IDX_ID_LO: byte_nxt = IDENT[7:0];
      dp_diag_pkg::IDX_LEN: byte_nxt = dp_diag_pkg::LEN_CODE;
      dp_diag_pkg::IDX_MSG: begin
        byte_nxt = trig_r[dp_diag_pkg::TRIG_VALID] ?
                   dp_diag_pkg::MSG_USER_OK : err_r;
      end
      default: begin
        if (idx_r >= dp_diag_pkg::IDX_USER) begin
          byte_nxt = pay_r[8*(idx_r - dp_diag_pkg::IDX_USER) +: 8];
        end else begin
          byte_nxt = 8'h00;
        end
      end
    endcase
  end

  // Frame engine registers; byte taken fresh in each load cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= dp_diag_pkg::ST_IDLE;
      idx_r <= 4'h0;
      byte_r <= 8'h00;
      last_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take_w) idx_r <= 4'h0;
      else if (beat_w && !done_w) idx_r <= idx_r + 4'h1;
      if (state_r == dp_diag_pkg::ST_LOAD) begin
        byte_r <= byte_nxt;
        last_r <= (idx_r == dp_diag_pkg::FRAME_LAST);
      end
    end
  end

  // Pending request and overflow; set wins over clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      pend_r <= start_evt || (pend_r && !take_w);
      ovf_r <= ovf_evt || (ovf_r && !trig_del);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Process image block
  // bytes behind status
  always_comb begin
    pay_nxt = pay_r;
    if (wr_pay) begin
      pay_nxt[8*pay_sel +: 8] = wdata_i;
    end
  end

  // Image storage; reserved status bits are not kept
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_r <= 8'h00;
      pay_r <= 40'h00_0000_0000;
    end else begin
      if (trig_take) trig_r <= wdata_i & dp_diag_pkg::TRIG_MASK;
      pay_r <= pay_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and latched status
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_r <= dp_diag_pkg::BASE_RST;
      stat1_r <= dp_diag_pkg::STAT1_RST;
      stat2_r <= dp_diag_pkg::STAT2_RST;
      msk_r <= dp_diag_pkg::MSK_RST;
      maddr_r <= dp_diag_pkg::MADDR_RST;
    end else begin
      if (wr_base) base_r <= wdata_i[5:0];
      if (wr_stat1) stat1_r <= wdata_i & dp_diag_pkg::STAT1_MASK;
      if (wr_stat2) stat2_r <= wdata_i & dp_diag_pkg::STAT2_MASK;
      if (wr_msk) msk_r <= wdata_i[2:0];
      if (parm_event_i) maddr_r <= parm_master_i;
    end
  end

  // Error code; a new error wins over a delete
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_r <= dp_diag_pkg::ERR_RST;
    end else if (err_event_i) begin
      err_r <= err_code_i;
    end else if (trig_del) begin
      err_r <= dp_diag_pkg::ERR_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags and interrupt
  wire [2:0] ev_w = {ovf_evt, trig_ign, done_w};
  genvar g;
  generate
    for (g = 0; g < dp_diag_pkg::IRQ_W; g++) begin : g_flag
      dp_sticky_flag u_flag (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .set_i(ev_w[g]),
        .clr_i(wr_irq && wdata_i[g]),
        .flag_o(flag_w[g])
      );
    end
  endgenerate
  assign irq_o = |(flag_w & msk_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data in the cycle after the strobe only
  always_comb begin
    rdata_nxt = 8'h00;
    if (in_blk && (rel_w == dp_diag_pkg::OFS_TRIG)) rdata_nxt = trig_r;
    else if (in_blk) rdata_nxt = pay_r[8*pay_sel +: 8];
    else begin
      case (addr_i)
        dp_diag_pkg::ADR_BASE: rdata_nxt = base_w;
        dp_diag_pkg::ADR_STAT1: rdata_nxt = stat1_r;
        dp_diag_pkg::ADR_STAT2: rdata_nxt = stat2_r;
        dp_diag_pkg::ADR_IRQ_ST: rdata_nxt = {5'h00, flag_w};
        dp_diag_pkg::ADR_IRQ_MSK: rdata_nxt = {5'h00, msk_r};
        dp_diag_pkg::ADR_ERR: rdata_nxt = err_r;
        dp_diag_pkg::ADR_MADDR: rdata_nxt = maddr_r;
        dp_diag_pkg::ADR_ENG: rdata_nxt = {6'h00, ovf_r, pend_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_r <= 8'h00;
    else rdata_r <= rd_i ? rdata_nxt : 8'h00;
  end

  assign rdata_o = rdata_r;
  assign frame_valid_o = (state_r == dp_diag_pkg::ST_SEND);
  assign frame_byte_o = byte_r;
  assign frame_last_o = last_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire load_w = (state_r == dp_diag_pkg::ST_LOAD);

  a_req_answered: assert property (
    diag_req_i |=> pend_r || load_w) else $error("request not taken");
  a_stat1_fixed: assert property (
    load_w && idx_r == 4'h0 |=> !byte_r[0] && !byte_r[5] && !byte_r[7])
    else $error("status one fixed bits wrong");
  a_stat2_fixed: assert property (
    load_w && idx_r == 4'h1 |=> byte_r[2] && !byte_r[7] && !byte_r[6])
    else $error("status two fixed bits wrong");
  a_stat3_overflow: assert property (
    load_w && idx_r == 4'h2 |=> byte_r == {$past(ovf_r), 7'h00})
    else $error("status three wrong");
  a_master_addr: assert property (
    load_w && idx_r == 4'h3 |=> byte_r == $past(maddr_r))
    else $error("master address wrong");
  a_ident_high: assert property (
    load_w && idx_r == 4'h4 |=> byte_r == IDENT[15:8])
    else $error("ident high byte wrong");
  a_len_code: assert property (
    load_w && idx_r == 4'h6 |=> byte_r == 8'h0a)
    else $error("length byte wrong");
  a_user_code: assert property (
    load_w && idx_r == 4'h7 && trig_r[0] |=> byte_r == 8'h40)
    else $error("user valid code wrong");
  a_user_map: assert property (
    load_w && idx_r == 4'hb |=> byte_r == $past(pay_r[7:0]))
    else $error("user byte mapping wrong");
  a_reserved_zero: assert property (
    load_w && idx_r inside {4'h8, 4'h9, 4'ha} |=> byte_r == 8'h00)
    else $error("reserved byte not zero");
  a_rise_sends: assert property (
    trig_rise && idle_w && !pend_r |=> pend_r ##1 load_w && idx_r == 4'h0)
    else $error("rising status did not send");
  a_ignore_quiet: assert property (
    wr_trig && wdata_i == 8'h03 && !diag_req_i && !err_event_i && !pend_r
    |=> !pend_r && $stable(trig_r)) else $error("03h status acted on");
  a_ident_low: assert property (
    load_w && idx_r == 4'h5 |=> byte_r == IDENT[7:0])
    else $error("ident low byte wrong");
  a_err_code: assert property (
    load_w && idx_r == 4'h7 && !trig_r[0] |=> byte_r == $past(err_r))
    else $error("error message code wrong");
  a_last_marker: assert property (
    load_w |=> frame_last_o == ($past(idx_r) == 4'hf))
    else $error("last marker misplaced");
  a_delete_clears: assert property (
    trig_del && !ovf_evt |=> !ovf_r)
    else $error("delete left overflow set");

  c_full_frame: cover property (done_w);
  c_overflow: cover property (ovf_evt);
  c_ignored: cover property (trig_ign);
  c_stall: cover property (frame_valid_o && !frame_ready_i [*2]);
  c_delete: cover property (trig_del && ovf_r);

endmodule // dp_diag_framer

// *** dv/dp_master_model.sv ***
// Bus master model that consumes diagnostic response bytes
`timescale 1ns/1ps
module dp_master_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic frame_valid_i,
  input wire logic [7:0] frame_byte_i,
  input wire logic frame_last_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output logic frame_ready_o,
  output logic [7:0] rx_o [16],
  output int frames_o,
  output int bad_o
);
  logic [3:0] idx_r; // Position of the next byte in the frame

  //////////////////////////////////////////////////////////////////////////
  // Ready: held low while stalled, every other cycle when slow
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_ready_o <= 1'b0;
    end else begin
      frame_ready_o <= !stall_i && !(slow_i && frame_ready_o);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Capture; a marker off byte 15 is a framing fault
  // collect sixteen bytes
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_r <= 4'h0;
      frames_o <= 0;
      bad_o <= 0;
    end else if (frame_valid_i && frame_ready_o) begin
      rx_o[idx_r] <= frame_byte_i;
      if (frame_last_i) begin
        // End of frame, must sit on byte 15
        frames_o <= frames_o + 1;
        bad_o <= bad_o + ((idx_r != 4'hf) ? 1 : 0);
        idx_r <= 4'h0;
      end else begin
        bad_o <= bad_o + ((idx_r == 4'hf) ? 1 : 0);
        idx_r <= idx_r + 4'h1;
      end
    end
  end
endmodule // dp_master_model

// *** dv/test_dp_diag_framer.sv ***
// Self-checking bench of the diagnostic response framer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  fails++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module test_dp_diag_framer;
  localparam logic [15:0] ID = 16'hc3a5; // Arbitrary ident value
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, parm_m = 8'h00, err_c = 8'h00;
  logic wr = 1'b0, rd = 1'b0, diag_req = 1'b0, parm_ev = 1'b0;
  logic err_ev = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [7:0] rdata, fbyte;
  logic fvalid, flast, fready, irq;
  logic [7:0] rx [16]; // Last frame seen by the master
  logic [7:0] ex [16]; // Expected frame
  logic [7:0] img [5]; // User bytes written into the image
  int frames, bad, fails = 0, checks_done = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  dp_diag_framer #(.IDENT(ID)) u_dp_diag_framer (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .diag_req_i(diag_req),
    .parm_event_i(parm_ev), .parm_master_i(parm_m), .err_event_i(err_ev),
    .err_code_i(err_c), .frame_valid_o(fvalid), .frame_ready_i(fready),
    .frame_byte_o(fbyte), .frame_last_o(flast), .irq_o(irq));

  dp_master_model u_dp_master_model (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .frame_valid_i(fvalid), .frame_byte_i(fbyte),
    .frame_last_i(flast), .stall_i(stall), .slow_i(slow),
    .frame_ready_o(fready), .rx_o(rx), .frames_o(frames), .bad_o(bad));

  //////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, also reached by an expired wait
  task automatic end_of_test;
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One-cycle register write, then a settle point for comb outputs
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    #1;
  endtask

  // Read: data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask

  // Single-cycle pulse on one of the event inputs
  task automatic pulse(input int which, input logic [7:0] d);
    @(posedge clk_sys_i);
    diag_req <= (which == 0);
    parm_ev <= (which == 1);
    err_ev <= (which == 2);
    parm_m <= d;
    err_c <= d;
    @(posedge clk_sys_i);
    {diag_req, parm_ev, err_ev} <= 3'h0;
  endtask

  // Bounded wait for a frame count; running out ends the test
  task automatic wait_frames(input int n);
    int k;
    for (k = 0; k < 4000 && frames < n; k++) @(posedge clk_sys_i);
    if (frames < n) begin
      fails++;
      end_of_test();
    end
    `CHK("frames", n, frames)
  endtask

  // Build the expected frame from the variable fields
  task automatic check_frame(input logic [7:0] s1, input logic [7:0] s2,
                             input logic [7:0] s3, input logic [7:0] ma,
                             input logic [7:0] code);
    int i;
    ex = '{default: 8'h00};
    {ex[0], ex[1], ex[2], ex[3]} = {s1, s2, s3, ma};
    {ex[4], ex[5], ex[6], ex[7]} = {ID[15:8], ID[7:0], 8'h0a, code};
    for (i = 0; i < 5; i++) ex[11 + i] = img[i];
    for (i = 0; i < 16; i++) `CHK("frame byte", ex[i], rx[i])
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int c;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    // Reset values and an unmapped place
    rd_reg(8'h81, 8'h02);
    rd_reg(8'h82, 8'h04);
    rd_reg(8'h80, 8'h00);
    rd_reg(8'h86, 8'hff);
    rd_reg(8'h85, 8'h00);
    rd_reg(8'h7f, 8'h00);
    `CHK("irq", 1'b0, irq)
    // Master request with every live status flag set, slow consumer
    wr_reg(8'h81, 8'hff);
    wr_reg(8'h82, 8'hff);
    rd_reg(8'h82, 8'h3b);
    pulse(1, 8'h21);
    img = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    for (c = 0; c < 5; c++) wr_reg(8'(c + 1), img[c]);
    wr_reg(8'h84, 8'h07);
    slow <= 1'b1;
    pulse(0, 8'h00);
    wait_frames(1);
    check_frame(8'h5e, 8'h3f, 8'h00, 8'h21, 8'h00);
    rd_reg(8'h83, 8'h01);
    `CHK("irq", 1'b1, irq)
    wr_reg(8'h83, 8'h01);
    `CHK("irq", 1'b0, irq)
    // Program start by a rising valid bit, then the ignored value
    wr_reg(8'h00, 8'h01);
    wait_frames(2);
    check_frame(8'h5e, 8'h3f, 8'h00, 8'h21, 8'h40);
    wr_reg(8'h00, 8'h00);
    wr_reg(8'h00, 8'h03);
    repeat (60) @(posedge clk_sys_i);
    `CHK("frames", 2, frames)
    rd_reg(8'h00, 8'h00);
    rd_reg(8'h83, 8'h03);
    wr_reg(8'h83, 8'h03);
    // Block moved to a new base location
    wr_reg(8'h80, 8'h10);
    img = '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'he5};
    for (c = 0; c < 5; c++) wr_reg(8'(c + 8'h11), img[c]);
    wr_reg(8'h10, 8'h01);
    wait_frames(3);
    check_frame(8'h5e, 8'h3f, 8'h00, 8'h21, 8'h40);
    // Every error message code, sent on its own
    wr_reg(8'h10, 8'h00);
    for (c = 0; c < 6; c++) begin
      pulse(2, 8'(8'h12 + c));
      wait_frames(4 + c);
      `CHK("message code", 8'(8'h12 + c), rx[7])
      rd_reg(8'h85, 8'(8'h12 + c));
    end
    // Stalled master: one frame running, one queued, one merged
    stall <= 1'b1;
    for (c = 0; c < 3; c++) begin
      pulse(0, 8'h00);
      repeat (4) @(posedge clk_sys_i);
    end
    stall <= 1'b0;
    wait_frames(11);
    repeat (80) @(posedge clk_sys_i);
    `CHK("frames", 11, frames)
    check_frame(8'h5e, 8'h3f, 8'h80, 8'h21, 8'h17);
    rd_reg(8'h83, 8'h05);
    // Overflow latched, nothing left pending
    rd_reg(8'h87, 8'h02);
    // Delete clears overflow and the error code
    wr_reg(8'h10, 8'h02);
    // Full-rate consumer for the last frame
    slow <= 1'b0;
    pulse(0, 8'h00);
    wait_frames(12);
    check_frame(8'h5e, 8'h3f, 8'h00, 8'h21, 8'h00);
    `CHK("framing faults", 0, bad)
    end_of_test();
  end
endmodule // test_dp_diag_framer
